// ===== acc_top.sv
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "acc_defs.svh"
module acc_top
  import acc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // converter side
  input  wire logic        hardware_trigger_input,
  input  wire logic        cmp_hi,
  input  wire logic        alt_clk_tick,
  input  wire logic        async_clk_tick,
  output logic [4:0]       mux_sel,
  output logic             sample_en,
  output logic [9:0]       dac_code,
  output logic             low_power_select,
  output logic             pin_disable_ch_nine,
  output logic             pin_disable_ch_eight,
  output logic             irq
);
  // software visible registers
  logic [4:0]  channel_select_r;
  logic        trigger_select_r;
  logic [7:0]  cfg_r;
  logic [1:0]  pin_dis_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_mask_r;
  logic [9:0]  result_r;
  logic        hwt_prev_r;
  logic        ack_nxt;

  // bus decode
  logic        wb_req;
  logic        wr_lane0;
  logic        hit_ctrl1;
  logic        hit_ctrl2;
  logic        hit_cfg;
  logic        hit_pindis;
  logic        hit_result;
  logic        hit_istat;
  logic        hit_imask;
  logic        hit_any;
  logic [31:0] rd_mux;

  // conversion control
  logic        conv_tick;
  logic        sar_busy;
  logic        sar_done;
  logic [9:0]  sar_result;
  logic [9:0]  sar_trial;
  logic        sar_sample;
  logic        module_off;
  logic        sw_start;
  logic        hw_start;
  logic        start;
  logic        abort;
  logic        ten_bit;
  logic        ref_hi_sel;
  logic        ref_lo_sel;
  logic        eff_cmp;
  logic        done_ev;
  logic        abort_ev;
  logic [7:0]  ctrl2_rd;
  logic [9:0]  dac_nxt;
  logic        dac_settled;
  logic        sar_tick;

  // a request is served once: ack drops the cycle after it is given
  assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wr_lane0   = wb_req & wb_we_i & wb_sel_i[0];
  assign hit_ctrl1  = (wb_adr_i == `ACC_OFF_CTRL1);
  assign hit_ctrl2  = (wb_adr_i == `ACC_OFF_CTRL2);
  assign hit_cfg    = (wb_adr_i == `ACC_OFF_CFG);
  assign hit_pindis = (wb_adr_i == `ACC_OFF_PINDIS);
  assign hit_result = (wb_adr_i == `ACC_OFF_RESULT);
  assign hit_istat  = (wb_adr_i == `ACC_OFF_IRQSTAT);
  assign hit_imask  = (wb_adr_i == `ACC_OFF_IRQMASK);
  assign hit_any    = hit_ctrl1 | hit_ctrl2 | hit_cfg | hit_pindis |
                      hit_result | hit_istat | hit_imask;
  assign ack_nxt    = wb_req & hit_any;

  // status byte: active flag is live converter state
  assign ctrl2_rd = {sar_busy, trigger_select_r, 6'h00};

  // read data, narrow registers in the low bits
  assign rd_mux = hit_ctrl1  ? {27'h0, channel_select_r} :
                  hit_ctrl2  ? {24'h0, ctrl2_rd} :
                  hit_cfg    ? {24'h0, cfg_r} :
                  hit_pindis ? {30'h0, pin_dis_r} :
                  hit_result ? {22'h0, result_r} :
                  hit_istat  ? {30'h0, irq_stat_r} :
                  hit_imask  ? {30'h0, irq_mask_r} : 32'h0;

  // trigger paths
  assign module_off = (channel_select_r == `ACC_CH_OFF);
  // software start on a write of the first control register naming a channel other than off, while software trigger is chosen
  assign sw_start = wr_lane0 & hit_ctrl1 & ~trigger_select_r &
                    (wb_dat_i[4:0] != `ACC_CH_OFF);
  // rising edge of the pin, only while hardware trigger is chosen
  assign hw_start = trigger_select_r & hardware_trigger_input &
                    ~hwt_prev_r & ~module_off;
  assign start    = (sw_start | hw_start) & ~sar_busy;
  // a new write to either control register or to config aborts a running one
  assign abort    = sar_busy & wr_lane0 & (hit_ctrl1 | hit_cfg | hit_ctrl2);
  assign abort_ev = abort;
  assign done_ev  = sar_done;

  assign ten_bit    = (cfg_r[`ACC_MODE_MSB:`ACC_MODE_LSB] == ACC_RES_10);
  assign ref_hi_sel = (channel_select_r == `ACC_CH_VHIGH);
  assign ref_lo_sel = (channel_select_r == `ACC_CH_VLOW);
  // internal references force the comparator: high gives full scale
  assign eff_cmp = ref_hi_sel ? 1'b1 : ref_lo_sel ? 1'b0 : cmp_hi;
  // eight bit trials sit in the top of the ten bit ladder
  assign dac_nxt     = ten_bit ? sar_trial : 10'({sar_trial[7:0], 2'h0});
  // comparator sees the registered ladder code: a step waits until the
  // ladder holds the current trial, costing a cycle per bit at ratio 1
  assign dac_settled = (dac_code == dac_nxt);
  assign sar_tick    = conv_tick & (sar_sample | dac_settled);

  acc_clkdiv u_div (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .run        (sar_busy),
    .src_sel    (cfg_r[`ACC_ICLK_MSB:`ACC_ICLK_LSB]),
    .div_sel    (cfg_r[`ACC_DIV_MSB:`ACC_DIV_LSB]),
    .alt_tick   (alt_clk_tick),
    .async_tick (async_clk_tick),
    .conv_tick  (conv_tick)
  );

  acc_sar u_sar (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .start     (start),
    .abort     (abort),
    .tick      (sar_tick),
    .ten_bit   (ten_bit),
    .long_smp  (cfg_r[`ACC_LSMP_BIT]),
    .cmp_hi    (eff_cmp),
    .sample_en (sar_sample),
    .trial     (sar_trial),
    .busy      (sar_busy),
    .done      (sar_done),
    .result    (sar_result)
  );

  // bus answer: one cycle after the request, unmapped gets err
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= ack_nxt;
      wb_err_o <= wb_req & ~hit_any;
      wb_dat_o <= ack_nxt ? rd_mux : 32'h0;
    end
  end

  // control registers, written through byte lane 0
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      channel_select_r <= `ACC_CH_RESET;
      trigger_select_r <= 1'b0;
      cfg_r            <= 8'h00;
      pin_dis_r        <= 2'h0;
      irq_mask_r       <= 2'h0;
    end else if (wr_lane0) begin
      if (hit_ctrl1) channel_select_r <= wb_dat_i[4:0];
      // bits 5:0 are reserved and dropped; software writes them as zero
      if (hit_ctrl2) trigger_select_r <= wb_dat_i[`ACC_TRG_BIT];
      if (hit_cfg) cfg_r <= wb_dat_i[7:0];
      if (hit_pindis) pin_dis_r <= wb_dat_i[1:0];
      if (hit_imask) irq_mask_r <= wb_dat_i[1:0];
    end
  end

  // sticky events: a set in the clearing cycle wins
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_stat_r <= 2'h0;
    end else begin
      irq_stat_r <= (irq_stat_r &
                     ~((wr_lane0 & hit_istat) ? wb_dat_i[1:0] : 2'h0)) |
                    {abort_ev, done_ev};
    end
  end

  // result holding and trigger edge memory
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      result_r   <= `ACC_ZERO;
      hwt_prev_r <= 1'b0;
    end else begin
      hwt_prev_r <= hardware_trigger_input;
      if (sar_done) begin
        // eight bit mode keeps only the low byte so full scale is ff
        result_r <= ten_bit ? sar_result : (sar_result & `ACC_FULL_8);
      end
    end
  end

  // registered outputs toward the analog front end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mux_sel              <= `ACC_CH_RESET;
      sample_en            <= 1'b0;
      dac_code             <= 10'h000;
      low_power_select     <= 1'b0;
      pin_disable_ch_nine  <= 1'b0;
      pin_disable_ch_eight <= 1'b0;
      irq                  <= 1'b0;
    end else begin
      mux_sel              <= channel_select_r;
      sample_en            <= sar_sample;
      dac_code             <= dac_nxt;
      low_power_select     <= cfg_r[`ACC_LPC_BIT];
      pin_disable_ch_nine  <= pin_dis_r[`ACC_PC9_BIT];
      pin_disable_ch_eight <= pin_dis_r[`ACC_PC8_BIT];
      irq                  <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule

// ===== acc_defs.svh
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
// register word addresses (byte offsets, one aligned word each)
`define ACC_OFF_CTRL1   8'h00
`define ACC_OFF_CTRL2   8'h04
`define ACC_OFF_CFG     8'h08
`define ACC_OFF_PINDIS  8'h0c
`define ACC_OFF_RESULT  8'h10
`define ACC_OFF_IRQSTAT 8'h14
`define ACC_OFF_IRQMASK 8'h18
// first status/control fields
`define ACC_CH_LSB      0
`define ACC_CH_MSB      4
`define ACC_CH_RSVD     5'h1c
`define ACC_CH_VHIGH    5'h1d
`define ACC_CH_VLOW     5'h1e
`define ACC_CH_OFF      5'h1f
`define ACC_CH_RESET    5'h1f
// trigger/status fields
`define ACC_ACT_BIT     7
`define ACC_TRG_BIT     6
// configuration fields
`define ACC_LPC_BIT     7
`define ACC_DIV_MSB     6
`define ACC_DIV_LSB     5
`define ACC_LSMP_BIT    4
`define ACC_MODE_MSB    3
`define ACC_MODE_LSB    2
`define ACC_ICLK_MSB    1
`define ACC_ICLK_LSB    0
`define ACC_MODE_8      2'h0
`define ACC_MODE_10     2'h2
// pin disable fields
`define ACC_PC9_BIT     1
`define ACC_PC8_BIT     0
// interrupt status bits
`define ACC_IRQ_DONE    0
`define ACC_IRQ_ABORT   1
// sample time in converter half cycles (3.5 and 23.5 cycles)
`define ACC_SMP_SHORT_HALF 8'd7
`define ACC_SMP_LONG_HALF  8'd47
// full scale codes
`define ACC_FULL_10     10'h3ff
`define ACC_FULL_8      10'h0ff
`define ACC_ZERO        10'h000
`endif

// ===== acc_pkg.sv
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_RES_8  = 2'h0,
    ACC_RES_R1 = 2'h1,
    ACC_RES_10 = 2'h2,
    ACC_RES_R3 = 2'h3
  } acc_res_t;
  typedef enum logic [1:0] {
    ACC_CLK_BUS  = 2'h0,
    ACC_CLK_BUS2 = 2'h1,
    ACC_CLK_ALT  = 2'h2,
    ACC_CLK_ASYN = 2'h3
  } acc_clksrc_t;
endpackage

// ===== acc_clkdiv.sv
`timescale 1ns/10ps
`include "acc_defs.svh"
// converter clock enable: source select then 1/2/4/8 divider
module acc_clkdiv
  import acc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       run,
  input  wire logic [1:0] src_sel,
  input  wire logic [1:0] div_sel,
  input  wire logic       alt_tick,
  input  wire logic       async_tick,
  output logic            conv_tick
);
  logic       half_r;
  logic [2:0] cnt_r;
  logic       src_tick;
  logic [2:0] limit;

  // input clock source as a one-cycle enable
  assign src_tick = (src_sel == ACC_CLK_BUS)  ? 1'b1 :
                    (src_sel == ACC_CLK_BUS2) ? half_r :
                    (src_sel == ACC_CLK_ALT)  ? alt_tick : async_tick;
  // ratio 1,2,4,8 from a two-bit code
  assign limit = 3'((4'h1 << div_sel) - 4'h1);
  // tick is left unregistered: a registered one would stretch sampling
  // by a whole converter cycle at ratio 1
  assign conv_tick = run & src_tick & (cnt_r == limit);

  // bus/2 phase also restarts per conversion, so timing is repeatable
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !run) begin
      half_r <= 1'b0;
    end else begin
      half_r <= ~half_r;
    end
  end

  // counter restarts with each conversion so phase is repeatable
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !run) begin
      cnt_r <= 3'h0;
    end else if (src_tick) begin
      cnt_r <= (cnt_r == limit) ? 3'h0 : 3'(cnt_r + 3'h1);
    end
  end
endmodule

// ===== acc_sar.sv
`timescale 1ns/10ps
`include "acc_defs.svh"
// successive approximation sequencer against a comparator input
module acc_sar
  import acc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       tick,
  input  wire logic       ten_bit,
  input  wire logic       long_smp,
  input  wire logic       cmp_hi,
  output logic            sample_en,
  output logic [9:0]      trial,
  output logic            busy,
  output logic            done,
  output logic [9:0]      result
);
  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_CONVERT} acc_sar_st_t;
  acc_sar_st_t st_r;
  logic [7:0]  half_r;
  logic [3:0]  bit_r;
  logic [9:0]  code_r;
  logic [7:0]  smp_half;
  logic [3:0]  top_bit;

  // sampling counted in converter half cycles: two per tick
  assign smp_half  = long_smp ? `ACC_SMP_LONG_HALF : `ACC_SMP_SHORT_HALF;
  assign top_bit   = ten_bit ? 4'd9 : 4'd7;
  assign sample_en = (st_r == S_SAMPLE);
  assign busy      = (st_r != S_IDLE);
  // trial weight being tested this step
  assign trial     = code_r | (10'h001 << bit_r);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r   <= S_IDLE;
      half_r <= 8'h00;
      bit_r  <= 4'h0;
      code_r <= 10'h000;
      done   <= 1'b0;
      result <= 10'h000;
    end else begin
      done <= 1'b0;
      unique case (st_r)
        S_IDLE: begin
          if (start) begin
            st_r   <= S_SAMPLE;
            half_r <= 8'h00;
            code_r <= 10'h000;
            bit_r  <= top_bit;
          end
        end
        S_SAMPLE: begin
          if (abort) begin
            st_r <= S_IDLE;
          end else if (tick) begin
            half_r <= 8'(half_r + 8'd2);
            if (8'(half_r + 8'd2) >= smp_half) begin
              st_r <= S_CONVERT; // odd half cycle rounds up to a tick
            end
          end
        end
        S_CONVERT: begin
          if (abort) begin
            st_r <= S_IDLE;
          end else if (tick) begin
            // above-or-equal keeps the bit: saturates to full scale
            if (cmp_hi) begin
              code_r <= trial;
            end
            if (bit_r == 4'h0) begin
              st_r   <= S_IDLE;
              done   <= 1'b1;
              result <= cmp_hi ? trial : code_r;
            end else begin
              bit_r <= 4'(bit_r - 4'h1);
            end
          end
        end
      endcase
    end
  end
endmodule

// ===== acc_props.sv
`timescale 1ns/10ps
// bus and converter-side checks on the control block
module acc_props (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [4:0]  mux_sel,
  input wire logic        sample_en,
  input wire logic [9:0]  dac_code,
  input wire logic        low_power_select,
  input wire logic        pin_disable_ch_nine,
  input wire logic        pin_disable_ch_eight,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // request taken this edge; write only when byte 0 is enabled
  wire        take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire        wr   = take && wb_we_i && wb_sel_i[0];
  logic [7:0] cfg_r;
  logic       trg_r;
  // shadows snooped off the bus, so starts can be predicted
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cfg_r <= 8'h00;
      trg_r <= 1'b0;
    end else if (wr && wb_adr_i == 8'h08) begin
      cfg_r <= wb_dat_i[7:0];
    end else if (wr && wb_adr_i == 8'h04) begin
      trg_r <= wb_dat_i[6];
    end
  end
  ans_pulse_a: assert property (take |=> (wb_ack_o || wb_err_o) ##1
    !(wb_ack_o || wb_err_o)) else $error("bus answer not one pulse");
  unmapped_err_a: assert property (take && wb_adr_i > 8'h18 |=>
    wb_err_o && !wb_ack_o) else $error("unmapped access not refused");
  dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  pins_follow_a: assert property (wr && wb_adr_i == 8'h0c |-> ##2
    {pin_disable_ch_nine, pin_disable_ch_eight} == $past(wb_dat_i[1:0], 2))
    else $error("pin disable outputs wrong");
  lpc_follow_a: assert property (wr && wb_adr_i == 8'h08 |-> ##2
    low_power_select == $past(wb_dat_i[7], 2))
    else $error("low power output wrong");
  chan_follow_a: assert property (wr && wb_adr_i == 8'h00 |-> ##2
    mux_sel == $past(wb_dat_i[4:0], 2)) else $error("channel out wrong");
  off_idle_a: assert property (mux_sel == 5'h1f &&
    $past(mux_sel) == 5'h1f |-> !sample_en)
    else $error("sampling while disabled");
  sw_start_a: assert property (wr && wb_adr_i == 8'h00 &&
    wb_dat_i[4:0] != 5'h1f && !trg_r && cfg_r[1:0] < 2'h2 && !cfg_r[2]
    |-> ##[1:40] sample_en) else $error("software start missing");
  mode8_a: assert property (cfg_r[3:2] == 2'h0 &&
    $changed(dac_code) |-> dac_code[1:0] == 2'h0)
    else $error("eight bit trial uses low bits");
  cover property ($rose(sample_en));
  cover property (wb_err_o);
  cover property ($rose(irq));
endmodule

// ===== acc_partner.sv
`timescale 1ns/10ps
// analog side: comparator on a held input, plus two free clock ticks
module acc_partner (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic [9:0] level,
  input  wire logic [9:0] dac_code,
  output logic            cmp_hi,
  output logic            alt_clk_tick,
  output logic            async_clk_tick
);
  logic [3:0] cnt_r;
  // input at or above the trial level compares high
  assign cmp_hi = level >= dac_code;
  // ticks are free running, so their phase to a start is arbitrary
  assign alt_clk_tick   = cnt_r % 4'd3 == 4'd0;
  assign async_clk_tick = cnt_r % 4'd5 == 4'd0;
  // mod 15 keeps both tick rates exact
  always_ff @(posedge sys_clk) begin
    if (!reset_n)
      cnt_r <= 4'h0;
    else
      cnt_r <= (cnt_r == 4'he) ? 4'h0 : cnt_r + 4'h1;
  end
endmodule

// ===== adc_control_config_test.sv
`timescale 1ns/10ps
// register-level tests of the converter control block
module adc_control_config_test;
  logic        sys_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic        wb_ack_o, wb_err_o, berr, hw_trg, cmp_hi, alt_t, asy_t;
  logic [4:0]  mux_sel;
  logic        sample_en, lps, pd9, pd8, irq;
  logic [9:0]  dac_code;
  int          err_total, cmp_count, cyc_n, run_n, smp_len;
  // per row: config, channel, result, sample cycles (0 = phase free)
  logic [7:0]  cfg_v [13] = '{8'h08, 8'h00, 8'h08, 8'h00, 8'h08, 8'h18,
    8'h28, 8'h48, 8'h68, 8'h09, 8'h0a, 8'h0b, 8'h88};
  logic [4:0]  chan_v [13] = '{5'h05, 5'h05, 5'h1d, 5'h1d, 5'h1e, 5'h05,
    5'h05, 5'h05, 5'h05, 5'h05, 5'h05, 5'h05, 5'h05};
  logic [9:0]  res_v [13] = '{10'h155, 10'h055, 10'h3ff, 10'h0ff, 10'h000,
    10'h155, 10'h155, 10'h155, 10'h155, 10'h155, 10'h155, 10'h155, 10'h155};
  int          smp_v [13] = '{4, 4, 4, 4, 4, 24, 8, 16, 32, 8, 0, 0, 4};
  acc_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .hardware_trigger_input(hw_trg),
    .cmp_hi(cmp_hi), .alt_clk_tick(alt_t), .async_clk_tick(asy_t),
    .mux_sel(mux_sel), .sample_en(sample_en), .dac_code(dac_code),
    .low_power_select(lps), .pin_disable_ch_nine(pd9),
    .pin_disable_ch_eight(pd8), .irq(irq));
  acc_partner u_ana (.sys_clk(sys_clk), .reset_n(reset_n), .level(10'h155),
    .dac_code(dac_code), .cmp_hi(cmp_hi), .alt_clk_tick(alt_t),
    .async_clk_tick(asy_t));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // cycle ceiling and length of the last sampling window
  always @(posedge sys_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000) begin
      err_total++;
      report_and_stop();
    end
    if (sample_en === 1'b1)
      run_n <= run_n + 1;
    else begin
      if (run_n != 0)
        smp_len <= run_n;
      run_n <= 0;
    end
  end
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one classic cycle, held until ack or err, then one idle cycle
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'h1;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
    if (n >= 50)
      err_total++;
    rdat = wb_dat_o;
    berr = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // poll the active flag; bounded so a stuck flag cannot hang us
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd(8'h04);
      n++;
    end while (rdat[7] !== 1'b0 && n < 300);
    chk(rdat & 32'h80, 32'h0);
  endtask
  // main sequence
  initial begin
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, hw_trg} = 5'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h0;
    {err_total, cmp_count, cyc_n, run_n, smp_len} = '0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h00);
    chk(rdat, 32'h1f);
    chk(32'(mux_sel), 32'h1f);
    $display("test reset done");
    for (int v = 0; v < 4; v++) begin
      wr(8'h0c, 32'(v));
      chk({30'h0, pd9, pd8}, 32'(v));
      rd(8'h0c);
      chk(rdat, 32'(v));
    end
    $display("test pins done");
    for (int i = 0; i < 13; i++) begin
      wr(8'h08, {24'h0, cfg_v[i]});
      chk(32'(lps), 32'(cfg_v[i][7]));
      wr(8'h00, {27'h0, chan_v[i]});
      rd(8'h04);
      chk(rdat & 32'h80, 32'h80);
      wait_idle();
      rd(8'h10);
      chk(rdat, {22'h0, res_v[i]});
      if (smp_v[i] != 0)
        chk(32'(smp_len), 32'(smp_v[i]));
    end
    $display("test conversions done");
    wr(8'h08, 32'h08);
    wr(8'h04, 32'h40);
    wr(8'h00, 32'h05);
    rd(8'h04);
    chk(rdat & 32'hc0, 32'h40);
    hw_trg <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(8'h04);
    chk(rdat & 32'hc0, 32'hc0);
    hw_trg <= 1'b0;
    wait_idle();
    wr(8'h04, 32'h00);
    $display("test trigger done");
    wr(8'h14, 32'h3);
    wr(8'h18, 32'h0);
    wr(8'h00, 32'h05);
    wait_idle();
    chk(32'(irq), 32'h0);
    rd(8'h14);
    chk(rdat, 32'h1);
    wr(8'h18, 32'h3);
    chk(32'(irq), 32'h1);
    wr(8'h14, 32'h1);
    wr(8'h00, 32'h05);
    wr(8'h08, 32'h08);
    rd(8'h04);
    chk(rdat & 32'h80, 32'h0);
    rd(8'h14);
    chk(rdat, 32'h2);
    chk(32'(irq), 32'h1);
    wr(8'h14, 32'h2);
    chk(32'(irq), 32'h0);
    $display("test interrupt done");
    rd(8'h40);
    chk(32'(berr), 32'h1);
    wr(8'h00, 32'h1f);
    rd(8'h04);
    chk(rdat & 32'h80, 32'h0);
    $display("test refusal done");
    report_and_stop();
  end
endmodule
bind acc_top acc_props u_props (.sys_clk(sys_clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .mux_sel(mux_sel), .sample_en(sample_en), .dac_code(dac_code),
  .low_power_select(low_power_select), .irq(irq),
  .pin_disable_ch_nine(pin_disable_ch_nine),
  .pin_disable_ch_eight(pin_disable_ch_eight));
